// file: bench/reader_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// reader: master of every command frame
// ----------------------------------------
module reader_model
	import tag_pkg::*;
(
	// clock
	input wire logic clk,
	// command frame
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic [7:0] cmd_arg,
	// tag answers
	input wire logic reply_valid,
	input wire logic [7:0] reply_id,
	input wire logic access_valid,
	input wire logic [7:0] access_code,
	input wire logic [2:0] tag_state
);
	logic got_r;
	logic got_a;
	logic [7:0] got_id;
	logic [7:0] got_c;
	logic [2:0] got_s;

	initial
	begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_arg = 8'h00;
	end

	// one frame; answers stand one cycle, so they are read one cycle on
	task automatic send(input logic [7:0] code, input logic [7:0] arg);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_arg = arg;
		@(negedge clk);
		got_r = reply_valid;
		got_id = reply_id;
		got_a = access_valid;
		got_c = access_code;
		got_s = tag_state;
		cmd_valid = 1'b0;
		// released lines must not keep looking like a frame
		cmd_code = ~code;
		cmd_arg = ~arg;
	endtask : send

	// slot 0 by the poll, then slots 1..15 by slot calls
	task automatic round(output int hits, output logic [7:0] hid, output int hslot);
		hits = 0;
		hid = 8'h00;
		hslot = 0;
		send(CMD_ANTICOL, SUB_ZERO_POLL);
		if (got_r === 1'b1)
		begin
			hits++;
			hid = got_id;
		end
		for (int s = 1; s < 16; s++)
		begin
			send({4'(s), SLOT_CALL_CODE}, 8'h00);
			if (got_r === 1'b1)
			begin
				hits++;
				hid = got_id;
				hslot = s;
			end
		end
	endtask : round
	// the bench picks one identified tag at a time
endmodule : reader_model
`default_nettype wire

// file: bench/tb_tag_state_anticollision.sv
`timescale 1ns/10ps
`default_nettype none
module tb_tag_state_anticollision;
	import tag_pkg::*;
	logic clock;
	logic arst_n;
	logic field_ok;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic [7:0] cmd_arg;
	logic reply_valid;
	logic [7:0] reply_id;
	logic access_valid;
	logic [7:0] access_code;
	logic [2:0] tag_state;
	int err_total;
	int n_tests;
	logic [31:0] seed;
	logic [2:0] m_state;
	logic [7:0] m_id;
	int hits;
	int hslot;
	logic [7:0] hid;
	logic [7:0] tbl [8];

	tag_state_anticollision uut (.CLOCK(clock), .ARST_N(arst_n), .FIELD_OK(field_ok),
		.CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_ARG(cmd_arg),
		.REPLY_VALID(reply_valid), .REPLY_ID(reply_id), .ACCESS_VALID(access_valid),
		.ACCESS_CODE(access_code), .TAG_STATE(tag_state));
	reader_model rdr (.clk(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_arg(cmd_arg), .reply_valid(reply_valid), .reply_id(reply_id),
		.access_valid(access_valid), .access_code(access_code), .tag_state(tag_state));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
		return seed[7:0];
	endfunction : rnd

	task automatic report_and_stop();
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : chk

	task automatic wait_state(input logic [2:0] s);
		for (int i = 0; i < 20 && tag_state !== s; i++)
			@(negedge clock);
		if (tag_state !== s)
		begin
			err_total++;
			report_and_stop();
		end
		m_state = s;
	endtask : wait_state

	// behavioural state model; in inventory, poll and slot calls go through the round
	task automatic cmd(input logic [7:0] c, input logic [7:0] a);
		logic [2:0] ns;
		logic rp;
		logic ac;
		ns = m_state;
		rp = 1'b0;
		ac = 1'b0;
		case (m_state)
			ST_READY: if (c == CMD_ANTICOL && a == SUB_BEGIN_INV)
			begin
				ns = ST_INVENTORY;
				rp = 1'b1;
			end
			ST_INVENTORY: if (c == CMD_ANTICOL && a == SUB_BEGIN_INV)
				rp = 1'b1;
			else if (c == CMD_PICK && a == m_id)
			begin
				ns = ST_SELECTED;
				rp = 1'b1;
			end
			ST_SELECTED: if (c == CMD_PICK)
			begin
				ns = (a == m_id) ? ST_SELECTED : ST_DESELECTED;
				rp = (a == m_id);
			end
			else if (c == CMD_FINISH)
				ns = ST_DEACTIVATED;
			else if (c == CMD_BACK_INV)
				ns = ST_INVENTORY;
			else if (c == CMD_BLOCK_READ || c == CMD_BLOCK_WRITE || c == CMD_SERIAL)
				ac = 1'b1;
			ST_DESELECTED: if (c == CMD_PICK && a == m_id)
			begin
				ns = ST_SELECTED;
				rp = 1'b1;
			end
			default: ;
		endcase
		rdr.send(c, a);
		chk("reply", {7'h00, rp}, {7'h00, rdr.got_r});
		chk("access", {7'h00, ac}, {7'h00, rdr.got_a});
		chk("state", 8'(ns), {5'h00, rdr.got_s});
		if (ac)
			chk("access code", c, rdr.got_c);
		if (rp && c == CMD_ANTICOL)
			m_id = rdr.got_id;
		else if (rp)
			chk("reply id", m_id, rdr.got_id);
		m_state = ns;
	endtask : cmd

	// ----------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	initial
	begin
		#500000;
		err_total++;
		report_and_stop();
	end

	initial
	begin
		arst_n = 1'b0;
		field_ok = 1'b0;
		err_total = 0;
		n_tests = 0;
		seed = 32'h0000_f30a;
		m_state = ST_OFF;
		m_id = 8'h00;
		tbl = '{CMD_ANTICOL, 8'h16, CMD_PICK, CMD_FINISH, CMD_BACK_INV, CMD_BLOCK_READ,
			CMD_BLOCK_WRITE, CMD_SERIAL};
		repeat (6) @(negedge clock);
		arst_n = 1'b1;
		repeat (4) @(negedge clock);
		cmd(CMD_ANTICOL, SUB_BEGIN_INV);
		field_ok = 1'b1;
		wait_state(ST_READY);
		for (int i = 0; i < 8; i++)
			cmd(tbl[i], (i == 0) ? SUB_ZERO_POLL : rnd());
		cmd(CMD_ANTICOL, SUB_BEGIN_INV);
		rdr.round(hits, hid, hslot);
		chk("slot answers", 8'h01, 8'(hits));
		chk("slot code", 8'(hslot), {4'h0, hid[3:0]});
		chk("id upper", {4'h0, m_id[7:4]}, {4'h0, hid[7:4]});
		m_id = hid;
		cmd(CMD_PICK, m_id);
		cmd(CMD_BACK_INV, rnd());
		cmd(CMD_ANTICOL, SUB_BEGIN_INV);
		cmd(CMD_PICK, m_id ^ {rnd() | 8'h01});
		cmd(CMD_PICK, m_id);
		for (int i = 5; i < 8; i++)
			cmd(tbl[i], rnd());
		cmd(CMD_ANTICOL, SUB_BEGIN_INV);
		cmd(CMD_ANTICOL, SUB_ZERO_POLL);
		cmd(8'h36, 8'h00);
		cmd(CMD_PICK, m_id);
		cmd(CMD_PICK, m_id ^ 8'h80);
		for (int i = 0; i < 8; i++)
			cmd(tbl[i], (i == 0) ? SUB_BEGIN_INV : m_id ^ 8'h10);
		cmd(CMD_PICK, m_id);
		cmd(CMD_FINISH, rnd());
		for (int i = 0; i < 8; i++)
			cmd(tbl[i], (i == 0) ? SUB_BEGIN_INV : m_id);
		field_ok = 1'b0;
		wait_state(ST_OFF);
		cmd(CMD_ANTICOL, SUB_BEGIN_INV);
		field_ok = 1'b1;
		wait_state(ST_READY);
		cmd(CMD_ANTICOL, SUB_BEGIN_INV);
		report_and_stop();
	end
endmodule : tb_tag_state_anticollision
`default_nettype wire

// file: rtl/rand_gen.sv
`timescale 1ns/10ps
`default_nettype none
module rand_gen
	import tag_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	rand_if.source rnd
);
	logic [15:0] lfsr_reg;
	logic [15:0] lfsr_next;

	// free running so that tags drift apart after power-up
	always_comb
	begin
		lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			lfsr_reg <= LFSR_SEED;
		else
			lfsr_reg <= lfsr_next;
	end

	assign rnd.value = lfsr_reg;
endmodule : rand_gen
`default_nettype wire

// file: rtl/rand_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rand_if;
	logic [15:0] value;
	modport source (output value);
	modport sink (input value);
endinterface : rand_if
`default_nettype wire

// file: rtl/tag_pkg.sv
package tag_pkg;
	// ----------------------------------------
	// command decode
	// ----------------------------------------
	localparam logic [7:0] CMD_ANTICOL = 8'h06;
	localparam logic [7:0] SUB_BEGIN_INV = 8'h00;
	localparam logic [7:0] SUB_ZERO_POLL = 8'h04;
	localparam logic [3:0] SLOT_CALL_CODE = 4'h6;
	localparam logic [7:0] CMD_PICK = 8'h0E;
	localparam logic [7:0] CMD_FINISH = 8'h0F;
	localparam logic [7:0] CMD_BACK_INV = 8'h0C;
	localparam logic [7:0] CMD_BLOCK_READ = 8'h08;
	localparam logic [7:0] CMD_BLOCK_WRITE = 8'h09;
	localparam logic [7:0] CMD_SERIAL = 8'h0B;
	// ----------------------------------------
	// reset values and widths
	// ----------------------------------------
	localparam int ID_W = 8;
	localparam int SLOT_W = 4;
	localparam logic [3:0] SLOT_ZERO = 4'h0;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [7:0] ID_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_READY = 3'b001,
		ST_INVENTORY = 3'b011,
		ST_SELECTED = 3'b010,
		ST_DESELECTED = 3'b110,
		ST_DEACTIVATED = 3'b111
	} tag_state_e;
endpackage : tag_pkg

// file: rtl/tag_state_anticollision.sv
`timescale 1ns/10ps
`default_nettype none
module tag_state_anticollision
	import tag_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic ARST_N,
	// field strength
	input wire logic FIELD_OK,
	// decoded command frame
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_CODE,
	input wire logic [7:0] CMD_ARG,
	// reply request
	output logic REPLY_VALID,
	output logic [7:0] REPLY_ID,
	// memory access grant
	output logic ACCESS_VALID,
	output logic [7:0] ACCESS_CODE,
	// state view
	output logic [2:0] TAG_STATE
);
	import tag_pkg::*;

	// ----------------------------------------
	// reset and field synchronisers
	// ----------------------------------------
	logic rst_s1_reg;
	logic rst_n;
	logic fld_s1_reg;
	logic fld_s2_reg;
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fld_s1_reg <= 1'b0;
			fld_s2_reg <= 1'b0;
		end
		else
		begin
			fld_s1_reg <= FIELD_OK;
			fld_s2_reg <= fld_s1_reg;
		end
	end

	// ----------------------------------------
	// random source
	// ----------------------------------------
	rand_if rnd ();
	rand_gen u_rand (
		.clk(CLOCK),
		.rst_n(rst_n),
		.rnd(rnd)
	);
	logic [15:0] rv;
	assign rv = rnd.value;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic is_begin;
	logic is_poll;
	logic is_slot;
	logic is_pick;
	logic is_finish;
	logic is_back;
	logic is_access;
	logic [3:0] slot_index;
	always_comb
	begin
		is_begin = CMD_CODE == CMD_ANTICOL && CMD_ARG == SUB_BEGIN_INV;
		is_poll = CMD_CODE == CMD_ANTICOL && CMD_ARG == SUB_ZERO_POLL;
		slot_index = CMD_CODE[7:4];
		// index zero belongs to the poll and is never a slot call
		is_slot = CMD_CODE[3:0] == SLOT_CALL_CODE && slot_index != SLOT_ZERO;
		is_pick = CMD_CODE == CMD_PICK;
		is_finish = CMD_CODE == CMD_FINISH;
		is_back = CMD_CODE == CMD_BACK_INV;
		is_access = CMD_CODE == CMD_BLOCK_READ || CMD_CODE == CMD_BLOCK_WRITE
			|| CMD_CODE == CMD_SERIAL;
	end

	// ----------------------------------------
	// state machine
	// ----------------------------------------
	tag_state_e state_reg;
	tag_state_e state_next;
	logic [7:0] id_reg;
	logic [7:0] id_next;
	logic rep_reg;
	logic rep_next;
	logic [7:0] rid_reg;
	logic [7:0] rid_next;
	logic acc_reg;
	logic acc_next;
	logic [7:0] acode_reg;
	logic [7:0] acode_next;
	logic pick_match;
	logic [3:0] new_slot;

	always_comb
	begin
		state_next = state_reg;
		id_next = id_reg;
		rep_next = 1'b0;
		rid_next = rid_reg;
		acc_next = 1'b0;
		acode_next = acode_reg;
		pick_match = CMD_ARG == id_reg;
		new_slot = rv[3:0];
		if (!fld_s2_reg)
		begin
			state_next = ST_OFF;
		end
		else
		begin
			case (state_reg)
				ST_OFF:
				begin
					state_next = ST_READY;
					id_next = rv[15:8];
				end
				ST_READY:
				begin
					// the identifier keeps drifting until the tag is inventoried
					id_next = rv[15:8];
					if (CMD_VALID && is_begin)
					begin
						state_next = ST_INVENTORY;
						rep_next = 1'b1;
						rid_next = rv[15:8];
					end
				end
				ST_INVENTORY:
				begin
					if (CMD_VALID)
					begin
						if (is_begin)
						begin
							id_next = rv[15:8];
							rep_next = 1'b1;
							rid_next = rv[15:8];
						end
						else if (is_poll)
						begin
							id_next = {id_reg[7:4], new_slot};
							rep_next = new_slot == SLOT_ZERO;
							rid_next = {id_reg[7:4], new_slot};
						end
						else if (is_slot)
						begin
							rep_next = id_reg[3:0] == slot_index;
							rid_next = id_reg;
						end
						else if (is_pick && pick_match)
						begin
							state_next = ST_SELECTED;
							rep_next = 1'b1;
							rid_next = id_reg;
						end
					end
				end
				ST_SELECTED:
				begin
					if (CMD_VALID)
					begin
						if (is_pick)
						begin
							if (pick_match)
							begin
								rep_next = 1'b1;
								rid_next = id_reg;
							end
							else
								state_next = ST_DESELECTED;
						end
						else if (is_finish)
							state_next = ST_DEACTIVATED;
						else if (is_back)
							state_next = ST_INVENTORY;
						else if (is_access)
						begin
							acc_next = 1'b1;
							acode_next = CMD_CODE;
						end
					end
				end
				ST_DESELECTED:
				begin
					if (CMD_VALID && is_pick && pick_match)
					begin
						state_next = ST_SELECTED;
						rep_next = 1'b1;
						rid_next = id_reg;
					end
				end
				ST_DEACTIVATED:
				begin
					state_next = ST_DEACTIVATED;
				end
				default:
				begin
					state_next = ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_OFF;
			id_reg <= ID_RESET;
			rep_reg <= 1'b0;
			rid_reg <= ID_RESET;
			acc_reg <= 1'b0;
			acode_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			id_reg <= id_next;
			rep_reg <= rep_next;
			rid_reg <= rid_next;
			acc_reg <= acc_next;
			acode_reg <= acode_next;
		end
	end

	assign REPLY_VALID = rep_reg;
	assign REPLY_ID = rid_reg;
	assign ACCESS_VALID = acc_reg;
	assign ACCESS_CODE = acode_reg;
	assign TAG_STATE = state_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_off_silent;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_OFF |=> !REPLY_VALID && !ACCESS_VALID;
	endproperty
	a_off_silent: assert property (p_off_silent) else $error("reply in power-off");

	property p_ready_begin;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_READY && fld_s2_reg && CMD_VALID && is_begin
		|=> state_reg == ST_INVENTORY && REPLY_VALID && REPLY_ID == id_reg;
	endproperty
	a_ready_begin: assert property (p_ready_begin) else $error("begin not taken");

	property p_ready_other;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_READY && fld_s2_reg && !(CMD_VALID && is_begin)
		|=> state_reg == ST_READY && !REPLY_VALID;
	endproperty
	a_ready_other: assert property (p_ready_other) else $error("ready reacted");

	property p_poll_zero;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_INVENTORY && fld_s2_reg && CMD_VALID && is_poll
		|=> REPLY_VALID == (id_reg[3:0] == SLOT_ZERO) && state_reg == ST_INVENTORY;
	endproperty
	a_poll_zero: assert property (p_poll_zero) else $error("poll answer wrong");

	property p_slot_call;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_INVENTORY && fld_s2_reg && CMD_VALID && is_slot
		|=> REPLY_VALID == ($past(id_reg[3:0]) == $past(CMD_CODE[7:4]));
	endproperty
	a_slot_call: assert property (p_slot_call) else $error("slot answer wrong");

	property p_sel_silent;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_SELECTED && CMD_VALID && (is_begin || is_poll || is_slot)
		|=> !REPLY_VALID;
	endproperty
	a_sel_silent: assert property (p_sel_silent) else $error("selected answered");

	property p_finish;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_SELECTED && fld_s2_reg && CMD_VALID && is_finish
		|=> state_reg == ST_DEACTIVATED ##1 state_reg != ST_SELECTED;
	endproperty
	a_finish: assert property (p_finish) else $error("finish failed");

	property p_deact;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_DEACTIVATED && fld_s2_reg |=> !REPLY_VALID && !ACCESS_VALID;
	endproperty
	a_deact: assert property (p_deact) else $error("deactivated reacted");

	property p_desel;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_DESELECTED && fld_s2_reg && !(CMD_VALID && is_pick && pick_match)
		|=> state_reg == ST_DESELECTED;
	endproperty
	a_desel: assert property (p_desel) else $error("deselected left");

	property p_back;
		@(posedge CLOCK) disable iff (!rst_n)
		state_reg == ST_SELECTED && fld_s2_reg && CMD_VALID && is_back
		|=> state_reg == ST_INVENTORY && !REPLY_VALID;
	endproperty
	a_back: assert property (p_back) else $error("back-to-inventory failed");
endmodule : tag_state_anticollision
`default_nettype wire
